// >>> src/tupe_pkg.sv
// Constants, field layouts and carrier types of the VLAN table walker.
// Assumes a 32-bit APB register bus and a VLAN table memory that returns
// read data one clock after the read strobe.
package tupe_pkg;

    // --------------------------------------------------------------------
    // Widths
    // --------------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int TAG_W = 16;
    localparam int PORT_W = 11;
    localparam int CNT_W = 4;
    localparam int UPD_W = 16;
    localparam int PADDR_W = 12;

    // --------------------------------------------------------------------
    // Register byte offsets
    // --------------------------------------------------------------------
    localparam logic [PADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [PADDR_W-1:0] OFS_RANGE = 12'h004;
    localparam logic [PADDR_W-1:0] OFS_CMD = 12'h008;
    localparam logic [PADDR_W-1:0] OFS_VALUE = 12'h00C;
    localparam logic [PADDR_W-1:0] OFS_BITS = 12'h010;
    localparam logic [PADDR_W-1:0] OFS_PORTS = 12'h014;
    localparam logic [PADDR_W-1:0] OFS_PCOUNT = 12'h018;
    localparam logic [PADDR_W-1:0] OFS_STATUS = 12'h01C;

    // --------------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------------
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_VAL_BIT = 1;
    localparam int CTRL_BIT_BIT = 2;
    localparam int CTRL_A_BIT = 3;
    localparam int CTRL_B_BIT = 4;
    localparam int CTRL_COMB_BIT = 5;
    localparam int HI_LSB = 16;

    // --------------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------------
    localparam logic [CNT_W-1:0] PCOUNT_RST = 4'hB;

    // One VLAN table entry as seen by the walker
    typedef struct packed {
        logic [TAG_W-1:0] group_tag;
        logic [PORT_W-1:0] port_mask;
    } vlan_entry_s;

    // Selection test enables
    typedef struct packed {
        logic value_en;
        logic bit_en;
        logic port_a_en;
        logic port_b_en;
        logic comb_en;
    } match_cfg_s;

endpackage : tupe_pkg

// >>> src/vlan_table_bulk_updater.sv
// VLAN table bulk updater: APB register file plus a walker that reads,
// filters, edits and writes back VLAN table entries.
// Assumes the table memory samples tbl_rd/tbl_wr at the clock edge and
// presents read data on tbl_rdata from the next cycle until the next read.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps

module vlan_table_bulk_updater import tupe_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // VLAN table memory
    output logic [ADDR_W-1:0] tbl_addr,
    output logic tbl_rd,
    output logic tbl_wr,
    output vlan_entry_s tbl_wdata,
    input wire vlan_entry_s tbl_rdata
);

    // --------------------------------------------------------------------
    // Declarations
    // --------------------------------------------------------------------
    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_EVAL, S_WRITE} walk_state_e;

    walk_state_e state;
    match_cfg_s cfg;
    logic [ADDR_W-1:0] first_addr;
    logic [ADDR_W-1:0] end_addr;
    logic [PORT_W-1:0] clear_cmd;
    logic [PORT_W-1:0] set_cmd;
    logic [TAG_W-1:0] compare_value;
    logic [TAG_W-1:0] value_mask;
    logic [TAG_W-1:0] bit_mask;
    logic [PORT_W-1:0] mask_a;
    logic [PORT_W-1:0] mask_b;
    logic [CNT_W-1:0] port_count;
    logic [UPD_W-1:0] upd_count;
    logic busy;
    logic wr_fire;
    logic start_req;
    logic [31:0] next_rdata;
    logic next_err;
    logic [ADDR_W-1:0] next_addr;
    logic more;
    logic [PORT_W-1:0] in_range;
    logic [PORT_W-1:0] clr_eff;
    logic [PORT_W-1:0] set_eff;
    logic [PORT_W-1:0] next_mask;
    logic pass_value;
    logic pass_bit;
    logic pass_a;
    logic pass_b;
    logic pass_comb;
    logic qualify;

    // Address decode shared by the read and the write path
    function automatic logic mapped(input logic [PADDR_W-1:0] a);
        mapped = (a == OFS_CTRL) || (a == OFS_RANGE) || (a == OFS_CMD) ||
                 (a == OFS_VALUE) || (a == OFS_BITS) ||
                 (a == OFS_PORTS) || (a == OFS_PCOUNT) ||
                 (a == OFS_STATUS);
    endfunction : mapped

    // --------------------------------------------------------------------
    // APB slave
    // --------------------------------------------------------------------

    // Writes land at the completing access edge only
    assign wr_fire = psel && penable && pready && pwrite;
    assign start_req = wr_fire && (paddr == OFS_CTRL) &&
                       pwdata[CTRL_START_BIT];
    assign busy = (state != S_IDLE);

    // Read data, built in the setup cycle and registered for the access
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = !mapped(paddr);
        unique case (paddr)
            OFS_CTRL: begin
                next_rdata[CTRL_START_BIT] = busy;
                next_rdata[CTRL_VAL_BIT] = cfg.value_en;
                next_rdata[CTRL_BIT_BIT] = cfg.bit_en;
                next_rdata[CTRL_A_BIT] = cfg.port_a_en;
                next_rdata[CTRL_B_BIT] = cfg.port_b_en;
                next_rdata[CTRL_COMB_BIT] = cfg.comb_en;
            end
            OFS_RANGE: begin
                next_rdata[ADDR_W-1:0] = first_addr;
                next_rdata[HI_LSB +: ADDR_W] = end_addr;
            end
            OFS_CMD: begin
                next_rdata[PORT_W-1:0] = clear_cmd;
                next_rdata[HI_LSB +: PORT_W] = set_cmd;
            end
            OFS_VALUE: begin
                next_rdata[TAG_W-1:0] = compare_value;
                next_rdata[HI_LSB +: TAG_W] = value_mask;
            end
            OFS_BITS: next_rdata[TAG_W-1:0] = bit_mask;
            OFS_PORTS: begin
                next_rdata[PORT_W-1:0] = mask_a;
                next_rdata[HI_LSB +: PORT_W] = mask_b;
            end
            OFS_PCOUNT: next_rdata[CNT_W-1:0] = port_count;
            OFS_STATUS: begin
                next_rdata[ADDR_W-1:0] = tbl_addr;
                next_rdata[HI_LSB +: UPD_W] = upd_count;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // One access cycle: pready rises the cycle after setup
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            pslverr <= next_err;
        end else begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // Configuration registers; changing them mid-walk is unsupported
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg <= '0;
            first_addr <= 13'h0000;
            end_addr <= 13'h0000;
            clear_cmd <= 11'h000;
            set_cmd <= 11'h000;
            compare_value <= 16'h0000;
            value_mask <= 16'h0000;
            bit_mask <= 16'h0000;
            mask_a <= 11'h000;
            mask_b <= 11'h000;
            port_count <= PCOUNT_RST;
        end else if (wr_fire && mapped(paddr)) begin
            unique case (paddr)
                OFS_CTRL: begin
                    cfg.value_en <= pwdata[CTRL_VAL_BIT];
                    cfg.bit_en <= pwdata[CTRL_BIT_BIT];
                    cfg.port_a_en <= pwdata[CTRL_A_BIT];
                    cfg.port_b_en <= pwdata[CTRL_B_BIT];
                    cfg.comb_en <= pwdata[CTRL_COMB_BIT];
                end
                OFS_RANGE: begin
                    first_addr <= pwdata[ADDR_W-1:0];
                    end_addr <= pwdata[HI_LSB +: ADDR_W];
                end
                OFS_CMD: begin
                    clear_cmd <= pwdata[PORT_W-1:0];
                    set_cmd <= pwdata[HI_LSB +: PORT_W];
                end
                OFS_VALUE: begin
                    compare_value <= pwdata[TAG_W-1:0];
                    value_mask <= pwdata[HI_LSB +: TAG_W];
                end
                OFS_BITS: bit_mask <= pwdata[TAG_W-1:0];
                OFS_PORTS: begin
                    mask_a <= pwdata[PORT_W-1:0];
                    mask_b <= pwdata[HI_LSB +: PORT_W];
                end
                OFS_PCOUNT: port_count <= pwdata[CNT_W-1:0];
                OFS_STATUS: port_count <= port_count; // Read only
            endcase
        end
    end

    // --------------------------------------------------------------------
    // Entry selection and editing
    // --------------------------------------------------------------------

    // Each test passes outright when its enable is off
    assign pass_value = !cfg.value_en ||
        ((tbl_rdata.group_tag & value_mask) == compare_value);
    assign pass_bit = !cfg.bit_en ||
        ((tbl_rdata.group_tag & bit_mask) != 16'h0000);
    assign pass_a = !cfg.port_a_en ||
        ((tbl_rdata.port_mask & mask_a) != 11'h000);
    assign pass_b = !cfg.port_b_en ||
        ((tbl_rdata.port_mask & mask_b) != 11'h000);
    assign pass_comb = !cfg.comb_en ||
        ((tbl_rdata.group_tag & bit_mask) != 16'h0000) ||
        ((tbl_rdata.port_mask & mask_a) != 11'h000);
    assign qualify = pass_value && pass_bit && pass_a && pass_comb &&
                     pass_b;

    // Per-port edit; ports at or above the count are left alone
    for (genvar p = 0; p < PORT_W; p++) begin : g_port
        assign in_range[p] = (CNT_W'(p) < port_count);
        assign clr_eff[p] = clear_cmd[p] && in_range[p];
        assign set_eff[p] = set_cmd[p] && in_range[p];
        assign next_mask[p] =
            (clr_eff[p] && set_eff[p]) ? !tbl_rdata.port_mask[p] :
            clr_eff[p] ? 1'b0 :
            set_eff[p] ? 1'b1 :
            tbl_rdata.port_mask[p];
    end

    // End bound is exclusive, as the walk loop stops before it
    assign next_addr = tbl_addr + 13'h0001;
    assign more = (next_addr < end_addr);

    // --------------------------------------------------------------------
    // Walker
    // --------------------------------------------------------------------

    // Read, evaluate, optionally write back, then step
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_IDLE;
            tbl_addr <= 13'h0000;
            tbl_rd <= 1'b0;
            tbl_wr <= 1'b0;
            tbl_wdata <= '0;
            upd_count <= 16'h0000;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (start_req) begin
                        tbl_addr <= first_addr;
                        upd_count <= 16'h0000;
                        if (first_addr < end_addr) begin
                            tbl_rd <= 1'b1;
                            state <= S_WAIT;
                        end
                    end
                end
                S_WAIT: begin
                    tbl_rd <= 1'b0;
                    state <= S_EVAL;
                end
                S_EVAL: begin
                    if (qualify) begin
                        tbl_wr <= 1'b1;
                        tbl_wdata.group_tag <= tbl_rdata.group_tag;
                        tbl_wdata.port_mask <= next_mask;
                        upd_count <= upd_count + 16'h0001;
                        state <= S_WRITE;
                    end else if (more) begin
                        tbl_addr <= next_addr;
                        tbl_rd <= 1'b1;
                        state <= S_WAIT;
                    end else begin
                        state <= S_IDLE;
                    end
                end
                S_WRITE: begin
                    tbl_wr <= 1'b0;
                    if (more) begin
                        tbl_addr <= next_addr;
                        tbl_rd <= 1'b1;
                        state <= S_WAIT;
                    end else begin
                        state <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // --------------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_LAUNCH: assert property (
        (state == S_IDLE) && start_req && (first_addr < end_addr)
        |=> tbl_rd && (tbl_addr == $past(first_addr)))
        else $error("walk did not start at the first address");

    AST_IN_RANGE: assert property (
        tbl_rd |-> (tbl_addr >= first_addr) && (tbl_addr < end_addr))
        else $error("table read outside the walk range");

    AST_VALUE_GATE: assert property (
        (state == S_EVAL) && cfg.value_en &&
        ((tbl_rdata.group_tag & value_mask) != compare_value)
        |=> !tbl_wr)
        else $error("value mismatch entry was written");

    AST_NO_QUALIFY: assert property (
        (state == S_EVAL) && !qualify |=> !tbl_wr ##1 !tbl_wr)
        else $error("unqualified entry was written");

    AST_TOGGLE: assert property (
        tbl_wr |-> (((tbl_wdata.port_mask ^ $past(tbl_rdata.port_mask)) &
                     clr_eff & set_eff) == (clr_eff & set_eff)))
        else $error("clear and set did not toggle");

    AST_CLEAR: assert property (
        tbl_wr |-> ((tbl_wdata.port_mask & clr_eff & ~set_eff) == 11'h000))
        else $error("cleared port bit still set");

    AST_SET: assert property (
        tbl_wr |-> ((~tbl_wdata.port_mask & set_eff & ~clr_eff) == 11'h000))
        else $error("set port bit still clear");

    AST_WRITE_BACK: assert property (
        tbl_wr |-> $past(tbl_rd, 2) && (tbl_addr == $past(tbl_addr, 2)) &&
                   (tbl_wdata.group_tag == $past(tbl_rdata.group_tag)))
        else $error("write back not to the entry just read");

    AST_UNTOUCHED: assert property (
        tbl_wr |-> (((tbl_wdata.port_mask ^ $past(tbl_rdata.port_mask)) &
                     ~(clr_eff | set_eff)) == 11'h000))
        else $error("port bit without command changed");

    AST_BUSY_READ: assert property (
        psel && !penable && !pwrite && (paddr == OFS_CTRL)
        |=> (prdata[CTRL_START_BIT] == $past(busy)))
        else $error("start bit readback differs from walk state");

    AST_BIT_GATE: assert property (
        (state == S_EVAL) && cfg.bit_en &&
        ((tbl_rdata.group_tag & bit_mask) == 16'h0000) |=> !tbl_wr)
        else $error("entry without a group bit was written");

    AST_PORT_A_GATE: assert property (
        (state == S_EVAL) && cfg.port_a_en &&
        ((tbl_rdata.port_mask & mask_a) == 11'h000) |=> !tbl_wr)
        else $error("entry outside port mask A was written");

    AST_PORT_B_GATE: assert property (
        (state == S_EVAL) && cfg.port_b_en &&
        ((tbl_rdata.port_mask & mask_b) == 11'h000) |=> !tbl_wr)
        else $error("entry outside port mask B was written");

    AST_COMB_GATE: assert property (
        (state == S_EVAL) && cfg.comb_en &&
        ((tbl_rdata.group_tag & bit_mask) == 16'h0000) &&
        ((tbl_rdata.port_mask & mask_a) == 11'h000) |=> !tbl_wr)
        else $error("entry failing the combined test was written");

    AST_QUALIFY_WRITE: assert property (
        (state == S_EVAL) && qualify |=> tbl_wr && $stable(tbl_addr))
        else $error("qualified entry was not written back");

    AST_SELF_CLEAR: assert property (
        (state == S_WRITE) && !more |=> (state == S_IDLE))
        else $error("walk did not end after the last entry");

endmodule : vlan_table_bulk_updater

// >>> test/vlan_table_model.sv
// Behavioural VLAN table memory seen from the walker's table port.
// Assumes one clock; read data appears the cycle after the read strobe
// and holds until the next read. Addresses stay below DEPTH.
`timescale 1ns/10ps
module vlan_table_model import tupe_pkg::*; #(
    parameter int DEPTH = 64
) (
    // Clock
    input wire logic clk,
    // Table port
    input wire logic [ADDR_W-1:0] tbl_addr,
    input wire logic tbl_rd,
    input wire logic tbl_wr,
    input wire vlan_entry_s tbl_wdata,
    output vlan_entry_s tbl_rdata
);
    // Tag and member mask per entry; the bench preloads it directly
    vlan_entry_s mem [DEPTH];
    logic [ADDR_W-1:0] last_rd;
    logic rd_open;
    int order_errs;

    // Start with a clean port so a stray read shows no stale entry
    initial begin
        order_errs = 0;
        rd_open = 1'b0;
        tbl_rdata = '0;
    end

    // A write must go back to the address just read, once per read
    always @(posedge clk) begin
        if (tbl_rd) begin
            tbl_rdata <= mem[tbl_addr];
            last_rd <= tbl_addr;
            rd_open <= 1'b1;
        end
        if (tbl_wr) begin
            if (!rd_open || tbl_addr !== last_rd) begin
                order_errs++;
            end
            mem[tbl_addr] <= tbl_wdata;
            rd_open <= 1'b0;
        end
    end
endmodule : vlan_table_model

// >>> test/test_vlan_table_bulk_updater.sv
// Self-checking bench for the VLAN table bulk updater.
// Assumes vlan_table_model on the table port; APB waits on pready.
`timescale 1ns/10ps
module test_vlan_table_bulk_updater import tupe_pkg::*;;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic tbl_rd, tbl_wr, re;
    logic [PADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, ctl, rq;
    logic [ADDR_W-1:0] tbl_addr, first, last;
    vlan_entry_s tbl_wdata, tbl_rdata;
    logic [PORT_W-1:0] clr_cmd, set_cmd, ma, mb;
    logic [TAG_W-1:0] cmp, vmask, bmask;
    logic [CNT_W-1:0] pcount;
    int mismatches, n_compared;

    vlan_table_bulk_updater vlan_table_bulk_updater_inst (.clk(clk),
        .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .tbl_addr(tbl_addr), .tbl_rd(tbl_rd),
        .tbl_wr(tbl_wr), .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata));
    vlan_table_model vlan_table_model_inst (.clk(clk), .tbl_addr(tbl_addr),
        .tbl_rd(tbl_rd), .tbl_wr(tbl_wr), .tbl_wdata(tbl_wdata),
        .tbl_rdata(tbl_rdata));

    // 250 MHz clock
    always #2 clk = ~clk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer, then an idle cycle so psel is never set twice
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        chk("pready", 32'h1, 32'(pready));
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer

    function automatic vlan_entry_s pat(int i);
        return {16'(i << 4), 11'(i * 37)};
    endfunction : pat

    // Reference selection: every enabled test must pass
    function automatic logic qual(vlan_entry_s e);
        logic tb, ta;
        tb = |(e.group_tag & bmask);
        ta = |(e.port_mask & ma);
        return (!ctl[CTRL_VAL_BIT] || (e.group_tag & vmask) == cmp)
            && (!ctl[CTRL_BIT_BIT] || tb)
            && (!ctl[CTRL_A_BIT] || ta)
            && (!ctl[CTRL_COMB_BIT] || tb || ta)
            && (!ctl[CTRL_B_BIT] || |(e.port_mask & mb));
    endfunction : qual

    // Defaults: value fields set but disabled, mixed port commands
    task automatic defaults();
        ctl = 32'h0;
        first = 13'h4;
        last = 13'h24;
        clr_cmd = 11'h0FC;
        set_cmd = 11'h30F;
        cmp = 16'h0050;
        vmask = 16'h00F0;
        bmask = 16'h0;
        ma = 11'h0;
        mb = 11'h0;
        pcount = 4'hB;
    endtask : defaults

    // Program, read back, start, poll, then judge every table entry
    task automatic run_walk();
        logic [11:0] a [6];
        logic [31:0] w [6];
        logic [PORT_W-1:0] en;
        logic busy;
        int cnt;
        int n;
        vlan_entry_s e;
        a = '{OFS_RANGE, OFS_CMD, OFS_VALUE, OFS_BITS, OFS_PORTS, OFS_PCOUNT};
        w = '{{3'h0, last, 3'h0, first}, {5'h0, set_cmd, 5'h0, clr_cmd},
              {vmask, cmp}, {16'h0, bmask}, {5'h0, mb, 5'h0, ma},
              {28'h0, pcount}};
        busy = (first < last);
        en = (pcount >= 11) ? 11'h7FF : 11'((1 << pcount) - 1);
        for (int i = 0; i < 64; i++) begin
            vlan_table_model_inst.mem[i] = pat(i);
        end
        for (int k = 0; k < 6; k++) begin
            xfer(1'b1, a[k], w[k]);
            xfer(1'b0, a[k], 32'h0);
            chk("config readback", w[k], rq);
        end
        xfer(1'b1, OFS_CTRL, ctl | 32'h1);
        xfer(1'b0, OFS_CTRL, 32'h0);
        chk("start while walking", ctl | 32'(busy), rq);
        n = 0;
        while (rq[CTRL_START_BIT] !== 1'b0 && n < 300) begin
            xfer(1'b0, OFS_CTRL, 32'h0);
            n++;
        end
        chk("start cleared", ctl, rq);
        cnt = 0;
        for (int i = 0; i < 64; i++) begin
            e = pat(i);
            if (i >= first && i < last && qual(e)) begin
                cnt++;
                e.port_mask ^= en & clr_cmd & set_cmd;
                e.port_mask &= ~(en & clr_cmd & ~set_cmd);
                e.port_mask |= en & set_cmd & ~clr_cmd;
            end
            chk("entry", 32'(vlan_table_model_inst.mem[i]), 32'(e));
        end
        chk("write order", 0, vlan_table_model_inst.order_errs);
        xfer(1'b0, OFS_STATUS, 32'h0);
        chk("written count", 32'(cnt), {16'h0, rq[31:16]});
        chk("walk stop address", busy ? 32'(last - 13'h1) : 32'(first),
            {19'h0, rq[12:0]});
    endtask : run_walk

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        logic [11:0] a;
        for (int k = 0; k < 8; k++) begin
            a = 12'(k * 4);
            xfer(1'b0, a, 32'h0);
            chk("reset value", (a == OFS_PCOUNT) ? 32'hB : 32'h0, rq);
            chk("mapped", 32'h0, 32'(re));
        end
        xfer(1'b0, 12'h020, 32'h0);
        chk("unmapped error", 32'h1, 32'(re));
        chk("unmapped data", 32'h0, rq);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_commands();
        defaults();
        run_walk();
        $display("test_commands done");
    endtask : test_commands

    task automatic test_value();
        defaults();
        ctl[CTRL_VAL_BIT] = 1'b1;
        last = 13'h40;
        run_walk();
        $display("test_value done");
    endtask : test_value

    task automatic test_bits_ports();
        defaults();
        ctl[CTRL_BIT_BIT] = 1'b1;
        ctl[CTRL_A_BIT] = 1'b1;
        ctl[CTRL_B_BIT] = 1'b1;
        bmask = 16'h0030;
        ma = 11'h0F0;
        mb = 11'h70F;
        run_walk();
        $display("test_bits_ports done");
    endtask : test_bits_ports

    task automatic test_comb();
        defaults();
        ctl[CTRL_COMB_BIT] = 1'b1;
        bmask = 16'h0041;
        ma = 11'h00F;
        run_walk();
        $display("test_comb done");
    endtask : test_comb

    task automatic test_pcount();
        defaults();
        pcount = 4'h4;
        first = 13'h0;
        last = 13'h40;
        run_walk();
        $display("test_pcount done");
    endtask : test_pcount

    task automatic test_empty();
        defaults();
        first = 13'hA;
        last = 13'hA;
        run_walk();
        $display("test_empty done");
    endtask : test_empty

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    // Main sequence: reset for 8 cycles, then each scenario in turn
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        mismatches = 0;
        n_compared = 0;
        defaults();
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        test_reset();
        test_commands();
        test_value();
        test_bits_ports();
        test_comb();
        test_pcount();
        test_empty();
        summarize();
    end

    // Watchdog at 50000 cycles, well beyond the under 1000 cycles the scenarios need
    initial begin
        #200000;
        mismatches++;
        summarize();
    end
endmodule : test_vlan_table_bulk_updater
